// [verilog/spc_counter.sv]
// setpoint pulse counter in up-counter mode with its four-byte bus images
//
// Overview of operation
// - output image is four bytes, setpoint one then setpoint two, high byte first.
// - input image: byte 1 diagnostic, bytes 2-3 count high first, byte 0 empty.
// - diagnostic byte shows resolution, mode, both reached flags and sync flag.
// - pulse rises are counted only while the enable input is held high.
// - every counted pulse rise adds exactly one to the count.
// - a setpoint written while its reached flag is clear takes effect at once.
// - a setpoint written while reached is held until the next enable rise.
// - a setpoint never written counts as zero.
// - enable rise clears count, both flags, both outputs and starts counting.
// - enable fall stops counting; outputs, flags and count stay readable.
// - count reaching setpoint one sets first flag, and first output with it only while the controller runs.
// - count reaching setpoint two sets second flag, and second output with it only while the controller runs.
// - count is reported as an unsigned 16-bit value 0 to 65535.
// - a setpoint left at zero switches its output on at the enable rise while the controller runs.
// - controller passing from run to stop switches both outputs off.
// - resolution switch ignored; pulses taken from the 5 V or 24 V input.
// - passing 65535 sets overflow bit 3, freezes flags and outputs except the run-to-stop switch-off, keeps counting.
// - after overflow an enable rise or a stop-to-run restart resets the counter.
`timescale 1ns/1ps
`include "spc_cfg.svh"
module spc_counter
   import spc_pkg::*;
(
   // clock, reset, clock enable
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clk_en,
   // output image write port, one byte per strobe
   input wire logic oia_wr,
   input wire logic [1:0] oia_addr,
   input wire logic [7:0] oia_data,
   // input image, byte 0 in bits 31:24
   output logic [31:0] input_image_area,
   // field inputs
   input wire logic pulse_5v,
   input wire logic pulse_24v,
   input wire logic enable_in,
   input wire logic plc_run,
   // operating mode switch
   input wire logic sw_level_24v,
   input wire logic [1:0] sw_resolution,
   input wire logic sw_mode_decoder,
   // setpoint outputs
   output logic target1_out,
   output logic target2_out
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   spc_state_t state_reg;
   spc_word_t count_reg;
   logic ovf_reg;
   spc_byte_t hi_stage_reg [`SPC_NUM_SP];
   spc_word_t sp_active_reg [`SPC_NUM_SP];
   spc_word_t sp_pend_reg [`SPC_NUM_SP];
   logic pend_valid_reg [`SPC_NUM_SP];
   logic hit_reg [`SPC_NUM_SP];
   logic out_reg [`SPC_NUM_SP];
   logic commit [`SPC_NUM_SP];
   logic [`SPC_NUM_EDGE-1:0] edge_in;
   logic [`SPC_NUM_EDGE-1:0] edge_rise;
   logic [`SPC_NUM_EDGE-1:0] edge_fall;
   logic pulse_sel;
   logic pulse_rise;
   logic ena_rise;
   logic ena_fall;
   logic run_rise;
   logic run_fall;
   logic clear_all;
   spc_byte_t diag;

   // ----------------------------------------------------------------
   // edge detection on pulse, enable and run inputs
   // ----------------------------------------------------------------
   // resolution switch plays no part here, only the level select
   assign pulse_sel = sw_level_24v ? pulse_24v : pulse_5v;
   assign edge_in = {plc_run, enable_in, pulse_sel};

   genvar e;
   generate
      for (e = 0; e < `SPC_NUM_EDGE; e++)
      begin : g_edge
         spc_edge u_edge
         (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .clk_en(clk_en),
            .sig_in(edge_in[e]),
            .rise(edge_rise[e]),
            .fall(edge_fall[e])
         );
      end
   endgenerate

   assign pulse_rise = edge_rise[0];
   assign ena_rise = edge_rise[1];
   assign ena_fall = edge_fall[1];
   assign run_rise = edge_rise[2];
   assign run_fall = edge_fall[2];
   // a restart from stop clears the same state as an enable rise
   assign clear_all = ena_rise | run_rise;

   // ----------------------------------------------------------------
   // counting state and count
   // ----------------------------------------------------------------
   // enable rise beats a pulse in the same cycle, so the count starts at zero
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= CS_STOPPED;
      end
      else if (clk_en)
      begin
         if (ena_rise)
         begin
            state_reg <= CS_COUNTING;
         end
         else if (ena_fall)
         begin
            state_reg <= CS_STOPPED;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count_reg <= `SPC_CNT_RST;
      end
      else if (clk_en)
      begin
         if (clear_all)
         begin
            count_reg <= `SPC_CNT_RST;
         end
         else if (pulse_rise && state_reg == CS_COUNTING && !ena_fall)
         begin
            // plain 16-bit add wraps from the maximum to zero
            count_reg <= count_reg + `SPC_CNT_STEP;
         end
      end
   end

   // overflow flag, cleared only by a restart or an enable rise
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ovf_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         if (clear_all)
         begin
            ovf_reg <= 1'b0;
         end
         else if (pulse_rise && state_reg == CS_COUNTING && !ena_fall &&
                  count_reg == `SPC_CNT_MAX)
         begin
            ovf_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // per-setpoint staging, hold-back and reached logic
   // ----------------------------------------------------------------
   genvar s;
   generate
      for (s = 0; s < `SPC_NUM_SP; s++)
      begin : g_sp
         // low byte completes the word; high byte waits in the stage
         assign commit[s] = oia_wr && oia_addr[`SPC_OIA_SEL_BIT] == s[0] &&
                            oia_addr[`SPC_OIA_LO_BIT];

         always_ff @(posedge clk_sys or negedge arst_n)
         begin
            if (!arst_n)
            begin
               hi_stage_reg[s] <= spc_byte_t'(`SPC_SP_RST >> 8);
            end
            else if (clk_en && oia_wr && oia_addr[`SPC_OIA_SEL_BIT] == s[0] &&
                     !oia_addr[`SPC_OIA_LO_BIT])
            begin
               hi_stage_reg[s] <= oia_data;
            end
         end

         // a write in the cycle of an enable rise meets a cleared flag
         always_ff @(posedge clk_sys or negedge arst_n)
         begin
            if (!arst_n)
            begin
               sp_active_reg[s] <= `SPC_SP_RST;
               sp_pend_reg[s] <= `SPC_SP_RST;
               pend_valid_reg[s] <= 1'b0;
            end
            else if (clk_en)
            begin
               if (commit[s] && (!hit_reg[s] || ena_rise))
               begin
                  sp_active_reg[s] <= {hi_stage_reg[s], oia_data};
                  pend_valid_reg[s] <= 1'b0;
               end
               else if (commit[s])
               begin
                  sp_pend_reg[s] <= {hi_stage_reg[s], oia_data};
                  pend_valid_reg[s] <= 1'b1;
               end
               else if (ena_rise && pend_valid_reg[s])
               begin
                  sp_active_reg[s] <= sp_pend_reg[s];
                  pend_valid_reg[s] <= 1'b0;
               end
            end
         end

         // flag and output set in one step; overflow freezes both, though a run fall still clears the output
         always_ff @(posedge clk_sys or negedge arst_n)
         begin
            if (!arst_n)
            begin
               hit_reg[s] <= 1'b0;
               out_reg[s] <= 1'b0;
            end
            else if (clk_en)
            begin
               if (clear_all)
               begin
                  hit_reg[s] <= 1'b0;
                  out_reg[s] <= 1'b0;
               end
               else if (run_fall)
               begin
                  out_reg[s] <= 1'b0;
               end
               else if (state_reg == CS_COUNTING && !ovf_reg && !hit_reg[s] &&
                        count_reg == sp_active_reg[s])
               begin
                  // zero setpoint matches right after the enable rise
                  hit_reg[s] <= 1'b1;
                  out_reg[s] <= plc_run;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // input image and outputs
   // ----------------------------------------------------------------
   // sync is a decoder-mode flag; it stays clear in counter mode
   always_comb
   begin
      diag = 8'h00;
      diag[`SPC_DIAG_SYNC] = `SPC_SYNC_CNT_MODE;
      diag[`SPC_DIAG_HIT1] = hit_reg[0];
      diag[`SPC_DIAG_HIT2] = hit_reg[1];
      diag[`SPC_DIAG_OVF] = ovf_reg;
      diag[`SPC_DIAG_RES_LSB +: 2] = sw_resolution;
      diag[`SPC_DIAG_MODE] = sw_mode_decoder;
      diag[`SPC_DIAG_SPARE] = 1'b0;
   end

   // image lags the state by one cycle so it comes from a flip-flop
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         input_image_area <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         input_image_area[`SPC_IIA_BYTE0_MSB -: 8] <= `SPC_IIA_BYTE0_VAL;
         input_image_area[`SPC_IIA_DIAG_MSB -: 8] <= diag;
         input_image_area[`SPC_IIA_CNT_MSB -: 16] <= count_reg;
      end
   end

   assign target1_out = out_reg[0];
   assign target2_out = out_reg[1];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   chk_count_step: assert property (
      clk_en && pulse_rise && state_reg == CS_COUNTING && !ena_fall && !clear_all
      |=> count_reg == $past(count_reg) + `SPC_CNT_STEP)
      else $error("count did not step by one");

   chk_enable_clear: assert property (
      clk_en && ena_rise
      |=> count_reg == `SPC_CNT_RST && !hit_reg[0] && !hit_reg[1] &&
          !target1_out && !target2_out && state_reg == CS_COUNTING)
      else $error("enable rise did not clear and arm");

   chk_fall_hold: assert property (
      clk_en && ena_fall && !clear_all
      |=> state_reg == CS_STOPPED && $stable(count_reg) && $stable(hit_reg[0]))
      else $error("enable fall disturbed state");

   chk_idle_frozen: assert property (
      state_reg == CS_STOPPED && !(clk_en && clear_all) |=> $stable(count_reg))
      else $error("count moved while stopped");

   chk_hit_one: assert property (
      clk_en && state_reg == CS_COUNTING && !ovf_reg && !hit_reg[0] && plc_run &&
      count_reg == sp_active_reg[0] && !clear_all && !run_fall
      |=> hit_reg[0] && target1_out)
      else $error("setpoint one reach missed");

   chk_hit_two: assert property (
      clk_en && state_reg == CS_COUNTING && !ovf_reg && !hit_reg[1] && plc_run &&
      count_reg == sp_active_reg[1] && !clear_all && !run_fall
      |=> hit_reg[1] && target2_out)
      else $error("setpoint two reach missed");

   chk_ovf_wrap: assert property (
      clk_en && pulse_rise && state_reg == CS_COUNTING && !ena_fall && !clear_all &&
      count_reg == `SPC_CNT_MAX
      |=> ovf_reg && count_reg == `SPC_CNT_RST ##1 input_image_area[`SPC_DIAG_OVF + 16])
      else $error("overflow not flagged or not wrapped");

   chk_ovf_freeze: assert property (
      ovf_reg && !(clk_en && clear_all) && !(clk_en && run_fall)
      |=> $stable(hit_reg[0]) && $stable(hit_reg[1]) && $stable(target1_out))
      else $error("flags moved during overflow");

   chk_run_stop: assert property (
      clk_en && run_fall |=> !target1_out && !target2_out)
      else $error("outputs not off after run to stop");

   chk_sp_held: assert property (
      clk_en && commit[0] && hit_reg[0] && !ena_rise
      |=> sp_active_reg[0] == $past(sp_active_reg[0]) && pend_valid_reg[0])
      else $error("setpoint taken while reached");

   chk_image_count: assert property (
      clk_en |=> input_image_area[15:0] == $past(count_reg) &&
                 input_image_area[31:24] == `SPC_IIA_BYTE0_VAL)
      else $error("input image does not follow state");

   cov_reach_one: cover property (ena_rise ##[1:40] hit_reg[0]);
   cov_overflow: cover property ($rose(ovf_reg));
   cov_pend_apply: cover property (pend_valid_reg[0] ##1 !pend_valid_reg[0]);
   cov_run_stop: cover property (target1_out ##1 run_fall);

endmodule

// [include/spc_cfg.svh]
// constants of the setpoint pulse counter: image layout, diagnostic bits, reset values
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// ----------------------------------------------------------------
// output image byte decode (byte address 0..3)
// ----------------------------------------------------------------
`define SPC_OIA_SP1_HI 2'h0
`define SPC_OIA_SP1_LO 2'h1
`define SPC_OIA_SP2_HI 2'h2
`define SPC_OIA_SP2_LO 2'h3
`define SPC_OIA_SEL_BIT 1
`define SPC_OIA_LO_BIT 0

// ----------------------------------------------------------------
// input image byte positions inside the 32-bit word, byte 0 on top
// ----------------------------------------------------------------
`define SPC_IIA_BYTE0_MSB 31
`define SPC_IIA_DIAG_MSB 23
`define SPC_IIA_CNT_MSB 15
`define SPC_IIA_BYTE0_VAL 8'h00

// ----------------------------------------------------------------
// diagnostic byte fields
// ----------------------------------------------------------------
`define SPC_DIAG_SYNC 0
`define SPC_DIAG_HIT1 1
`define SPC_DIAG_HIT2 2
`define SPC_DIAG_OVF 3
`define SPC_DIAG_RES_LSB 4
`define SPC_DIAG_MODE 6
`define SPC_DIAG_SPARE 7

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define SPC_SP_RST 16'h0000
`define SPC_CNT_RST 16'h0000
`define SPC_CNT_MAX 16'hFFFF
`define SPC_CNT_STEP 16'h0001
`define SPC_SYNC_CNT_MODE 1'b0
`define SPC_NUM_SP 2
`define SPC_NUM_EDGE 3

`endif

// [include/spc_pkg.sv]
// types shared by the setpoint pulse counter
package spc_pkg;

   // ----------------------------------------------------------------
   // common types
   // ----------------------------------------------------------------
   typedef logic [15:0] spc_word_t;
   typedef logic [7:0] spc_byte_t;

   // counting state: armed by an enable rise, halted by its fall
   typedef enum logic {CS_STOPPED, CS_COUNTING} spc_state_t;

endpackage

// [verilog/spc_edge.sv]
// rise and fall detector for one synchronous input
`timescale 1ns/1ps
module spc_edge
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clk_en,
   // observed level
   input wire logic sig_in,
   // detected edges, valid in the cycle the new level is seen
   output logic rise,
   output logic fall
);

   logic prev_reg;

   // ----------------------------------------------------------------
   // previous level; starts low so a level high at release reads as a rise
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prev_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         prev_reg <= sig_in;
      end
   end

   // edges compare against the held level
   assign rise = sig_in & ~prev_reg;
   assign fall = ~sig_in & prev_reg;

endmodule

// [verification/spc_plc_model.sv]
// controller side model: writes setpoints over the output image, drives run/stop
`timescale 1ns/1ps
module spc_plc_model
(
   // clock
   input wire logic clk_sys,
   // controller state
   output logic plc_run,
   // output image write port
   output logic oia_wr,
   output logic [1:0] oia_addr,
   output logic [7:0] oia_data
);
   // ----------------------------------------
   // idle values
   // ----------------------------------------
   // run at power-up, so the release of reset acts as a restart
   initial
   begin
      plc_run = 1'b1;
      oia_wr = 1'b0;
      oia_addr = 2'h0;
      oia_data = 8'h00;
   end

   // one setpoint, high byte then low byte, back to back
   task automatic wr_sp(input logic idx, input logic [15:0] val);
      @(posedge clk_sys);
      oia_wr <= 1'b1;
      oia_addr <= {idx, 1'b0};
      oia_data <= val[15:8];
      @(posedge clk_sys);
      oia_addr <= {idx, 1'b1};
      oia_data <= val[7:0];
      @(posedge clk_sys);
      oia_wr <= 1'b0;
      // released data no longer shows the last byte
      oia_data <= ~val[7:0];
   endtask

   // run/stop transition of the controller
   task automatic set_run(input logic v);
      @(posedge clk_sys);
      plc_run <= v;
   endtask
endmodule

// [verification/setpoint_pulse_counter_tb.sv]
// self-checking bench for the setpoint pulse counter in up-counter mode
`timescale 1ns/1ps
module setpoint_pulse_counter_tb;
   import spc_pkg::*;
   logic clk_sys;
   logic arst_n;
   logic plc_run;
   logic oia_wr;
   logic [1:0] oia_addr;
   logic [7:0] oia_data;
   logic [31:0] input_image_area;
   logic pulse_5v;
   logic pulse_24v;
   logic enable_in;
   logic sw_level_24v;
   logic [1:0] sw_resolution;
   logic sw_mode_decoder;
   logic target1_out;
   logic target2_out;
   int fails = 0;
   int samples_checked = 0;

   // ----------------------------------------
   // clock, reset, instances
   // ----------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   spc_plc_model plc
   (
      .clk_sys(clk_sys),
      .plc_run(plc_run),
      .oia_wr(oia_wr),
      .oia_addr(oia_addr),
      .oia_data(oia_data)
   );

   // clk_en tied high: gating is not part of the documented behaviour
   spc_counter dut
   (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .clk_en(1'b1),
      .oia_wr(oia_wr),
      .oia_addr(oia_addr),
      .oia_data(oia_data),
      .input_image_area(input_image_area),
      .pulse_5v(pulse_5v),
      .pulse_24v(pulse_24v),
      .enable_in(enable_in),
      .plc_run(plc_run),
      .sw_level_24v(sw_level_24v),
      .sw_resolution(sw_resolution),
      .sw_mode_decoder(sw_mode_decoder),
      .target1_out(target1_out),
      .target2_out(target2_out)
   );

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic test_done;
      if (fails == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // whole image plus both outputs, sampled mid-cycle where settled
   task automatic chk_all(input logic h1, input logic h2, input logic [15:0] cnt,
                          input logic t1, input logic t2);
      logic [7:0] d;
      d = {1'b0, sw_mode_decoder, sw_resolution, 1'b0, h2, h1, 1'b0};
      @(negedge clk_sys);
      chk("image", {input_image_area, target1_out, target2_out}, {8'h00, d, cnt, t1, t2});
   endtask

   // enable level change, then let the compare and image settle
   task automatic en(input logic v);
      @(posedge clk_sys);
      enable_in <= v;
      repeat (3) @(posedge clk_sys);
   endtask

   // n pulses, high one cycle and low one cycle each
   task automatic pulse(input int n, input logic line24);
      repeat (n)
      begin
         @(posedge clk_sys);
         if (line24)
            pulse_24v <= 1'b1;
         else
            pulse_5v <= 1'b1;
         @(posedge clk_sys);
         pulse_24v <= 1'b0;
         pulse_5v <= 1'b0;
      end
      repeat (3) @(posedge clk_sys);
   endtask

   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   initial
   begin
      repeat (2000) @(posedge clk_sys);
      fails++;
      test_done;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      arst_n = 1'b0;
      pulse_5v = 1'b0;
      pulse_24v = 1'b0;
      enable_in = 1'b0;
      sw_level_24v = 1'b0;
      sw_resolution = 2'h3;
      sw_mode_decoder = 1'b0;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk_all(1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
      // unwritten setpoints act as zero and fire at the enable rise
      en(1'b1);
      chk_all(1'b1, 1'b1, 16'h0000, 1'b1, 1'b1);
      en(1'b0);
      // both reached: new values wait for the next enable rise
      plc.wr_sp(1'b0, 16'h0002);
      plc.wr_sp(1'b1, 16'h0004);
      pulse(1, 1'b0);
      chk_all(1'b1, 1'b1, 16'h0000, 1'b1, 1'b1);
      en(1'b1);
      chk_all(1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
      pulse(2, 1'b0);
      chk_all(1'b1, 1'b0, 16'h0002, 1'b1, 1'b0);
      pulse(2, 1'b0);
      chk_all(1'b1, 1'b1, 16'h0004, 1'b1, 1'b1);
      plc.wr_sp(1'b0, 16'h0003);
      en(1'b0);
      pulse(1, 1'b0);
      chk_all(1'b1, 1'b1, 16'h0004, 1'b1, 1'b1);
      en(1'b1);
      // sp2 flag is clear after the rise, so this write is live at once
      plc.wr_sp(1'b1, 16'h0001);
      pulse(1, 1'b0);
      chk_all(1'b0, 1'b1, 16'h0001, 1'b0, 1'b1);
      pulse(2, 1'b0);
      chk_all(1'b1, 1'b1, 16'h0003, 1'b1, 1'b1);
      // unselected level input is ignored; switch fields only reported
      @(posedge clk_sys);
      sw_resolution <= 2'h1;
      sw_mode_decoder <= 1'b1;
      pulse(1, 1'b1);
      chk_all(1'b1, 1'b1, 16'h0003, 1'b1, 1'b1);
      @(posedge clk_sys);
      sw_level_24v <= 1'b1;
      pulse(1, 1'b1);
      chk_all(1'b1, 1'b1, 16'h0004, 1'b1, 1'b1);
      plc.set_run(1'b0);
      repeat (3) @(posedge clk_sys);
      chk_all(1'b1, 1'b1, 16'h0004, 1'b0, 1'b0);
      plc.set_run(1'b1);
      repeat (3) @(posedge clk_sys);
      chk_all(1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
      test_done;
   end
endmodule
